//--- inc/acr_pkg.sv
/*
 constants shared by both ends of the calibration and range control link.
 assumes mclk stands in for the converter sample clock, one cycle per input clock.
*/
package acr_pkg;
   localparam int CAL_HOLD_CYCLES = 80;
   localparam int POWERUP_CYCLES = 8388608;
   // calibration length given as a time at a reference input clock rate
   localparam longint CAL_TIME_NSEC = 64'd1160000;
   localparam longint REF_CLK_MHZ = 64'd2500;
   localparam longint CAL_CYCLES = CAL_TIME_NSEC * REF_CLK_MHZ / 64'd1000;
   localparam longint CLK_MHZ = 64'd125;
   localparam longint AUTO_CAL_TIME_S = 64'd20;
   localparam longint AUTO_CAL_CYCLES = AUTO_CAL_TIME_S * CLK_MHZ * 64'd1000000;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CONV_COUNT = 4;
   localparam int SAMPLE_W = 10;
   localparam logic [ADDR_W-1:0] APERTURE_EN_ADDR = 8'h01;
   localparam logic [ADDR_W-1:0] TERM_SEL_ADDR = 8'h02;
   localparam logic [ADDR_W-1:0] APERTURE_DLY_ADDR = 8'h0C;
   localparam logic [ADDR_W-1:0] OVR_CTRL_ADDR = 8'h14;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h15;
   localparam logic [ADDR_W-1:0] RANGE_BASE_ADDR = 8'h20;
   localparam int APERTURE_EN_BIT = 0;
   localparam int TERM_SEL_BIT = 14;
   localparam int OVR_DIS_BIT = 14;
   localparam int STAT_CAL_BIT = 0;
   localparam int STAT_DOWN_BIT = 1;
   localparam int STAT_DONE_BIT = 2;
   localparam logic APERTURE_EN_RST = 1'b0;
   localparam logic TERM_SEL_RST = 1'b0;
   localparam logic OVR_DIS_RST = 1'b1;
   localparam logic [DATA_W-1:0] APERTURE_DLY_RST = 16'h0000;
   localparam logic [DATA_W-1:0] RANGE_RST = 16'h0000;
   localparam logic signed [SAMPLE_W-1:0] CODE_MIN = 10'sh000;
   localparam logic signed [SAMPLE_W-1:0] CODE_MAX = 10'sh0FF;
endpackage

//--- inc/acr_link_if.sv
/*
 control pins between the converter device end and its host controller.
 assumes both ends run on the same mclk; each modport names one party.
*/
`timescale 1ns/100ps
interface acr_link_if (
   input wire logic mclk
);
   logic cal_req;
   logic power_down_pin;
   logic cal_in_progress;
   logic over_range_flag_p;
   logic over_range_flag_n;
   logic cfg_wr;
   logic [acr_pkg::ADDR_W-1:0] cfg_addr;
   logic [acr_pkg::DATA_W-1:0] cfg_wdata;
   modport dev (
      input cal_req,
      input power_down_pin,
      input cfg_wr,
      input cfg_addr,
      input cfg_wdata,
      output cal_in_progress,
      output over_range_flag_p,
      output over_range_flag_n
   );
   modport host (
      output cal_req,
      output power_down_pin,
      output cfg_wr,
      output cfg_addr,
      output cfg_wdata,
      input cal_in_progress,
      input over_range_flag_p,
      input over_range_flag_n
   );
endinterface

//--- rtl/acr_req_qual.sv
/*
 qualifies the calibration request pin: long low, then long high.
 assumes pin_level is already synchronised to mclk.
*/
`timescale 1ns/100ps
module acr_req_qual #(
   parameter int HOLD = acr_pkg::CAL_HOLD_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin_level,
   input wire logic ignore,
   output logic fire
);
   if (HOLD < 2 || HOLD > 255) begin : g_bad_hold
      $error("acr_req_qual: HOLD out of range");
   end

   logic [7:0] low_cnt_reg;
   logic [7:0] high_cnt_reg;
   logic armed_reg;
   logic prev_reg;
   logic fire_reg;

   assign fire = fire_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         low_cnt_reg <= 8'h00;
         high_cnt_reg <= 8'h00;
         armed_reg <= 1'b0;
         prev_reg <= 1'b0;
         fire_reg <= 1'b0;
      end else if (ignore) begin
         // requests made while powered down are dropped
         low_cnt_reg <= 8'h00;
         high_cnt_reg <= 8'h00;
         armed_reg <= 1'b0;
         prev_reg <= pin_level;
         fire_reg <= 1'b0;
      end else begin
         prev_reg <= pin_level;
         fire_reg <= 1'b0;
         if (!pin_level) begin
            // a level change restarts the count
            high_cnt_reg <= 8'h00;
            if (prev_reg) begin
               low_cnt_reg <= 8'h01;
               armed_reg <= 1'b0;
            end else if (low_cnt_reg != HOLD[7:0]) begin
               low_cnt_reg <= low_cnt_reg + 8'h01;
            end
            if (low_cnt_reg == HOLD[7:0] - 8'h01) begin
               armed_reg <= 1'b1;
            end
         end else begin
            low_cnt_reg <= 8'h00;
            if (armed_reg) begin
               high_cnt_reg <= high_cnt_reg + 8'h01;
               // start fires on the hold-th high cycle after the rise
               if (high_cnt_reg == HOLD[7:0] - 8'h01) begin
                  fire_reg <= 1'b1;
                  armed_reg <= 1'b0;
               end
            end
         end
      end
   end
endmodule

//--- rtl/acr_device.sv
/*
 device end: power-on and on-command calibration sequencing, over-range flag,
 clock termination select, aperture delay and range registers.
 assumes mclk is the sample input clock; link pins come from another chip.
*/
`timescale 1ns/100ps
module acr_device #(
   parameter int unsigned POWERUP_CYCLES = acr_pkg::POWERUP_CYCLES,
   parameter int unsigned CAL_CYCLES = 32'(acr_pkg::CAL_CYCLES)
) (
   input wire logic mclk,
   input wire logic rst_n,
   acr_link_if.dev link,
   input wire logic signed [acr_pkg::SAMPLE_W-1:0] conv_value_a,
   input wire logic signed [acr_pkg::SAMPLE_W-1:0] conv_value_b,
   input wire logic [acr_pkg::ADDR_W-1:0] rd_addr,
   output logic [acr_pkg::DATA_W-1:0] rd_data,
   output logic term_150_sel,
   output logic [acr_pkg::DATA_W-1:0] aperture_delay,
   output logic [acr_pkg::CONV_COUNT-1:0][acr_pkg::DATA_W-1:0] range_word,
   output logic powered_down,
   output logic calibrated
);
   if (POWERUP_CYCLES < 1 || CAL_CYCLES < 1) begin : g_bad_count
      $error("acr_device: counts must be positive");
   end

   typedef enum logic [2:0] {
      ST_STRAP,
      ST_PWRUP_WAIT,
      ST_IDLE,
      ST_CAL,
      ST_POWER_DOWN
   } acr_state_type;

   acr_state_type state_reg;
   acr_state_type state_next;
   logic [1:0] req_sync_reg;
   logic [1:0] down_sync_reg;
   logic [1:0] strap_cnt_reg;
   logic skip_reg;
   logic [31:0] cnt_reg;
   logic fire;
   logic cal_reg;
   logic flag_p_reg;
   logic flag_n_reg;
   logic done_reg;
   logic ap_en_reg;
   logic term_reg;
   logic ovr_dis_reg;
   logic [acr_pkg::DATA_W-1:0] ap_dly_reg;
   logic [acr_pkg::DATA_W-1:0] ap_out_reg;
   logic [acr_pkg::CONV_COUNT-1:0][acr_pkg::DATA_W-1:0] range_reg;
   logic [acr_pkg::DATA_W-1:0] rd_reg;
   logic down_out_reg;
   logic req_s;
   logic down_s;
   logic clip;

   assign req_s = req_sync_reg[1];
   assign down_s = down_sync_reg[1];
   assign link.cal_in_progress = cal_reg;
   assign link.over_range_flag_p = flag_p_reg;
   assign link.over_range_flag_n = flag_n_reg;
   assign rd_data = rd_reg;
   assign term_150_sel = term_reg;
   assign aperture_delay = ap_out_reg;
   assign range_word = range_reg;
   assign powered_down = down_out_reg;
   assign calibrated = done_reg;

   // request and power-down pins from the host pass two flops first
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_sync_reg <= 2'b00;
         down_sync_reg <= 2'b00;
      end else begin
         req_sync_reg <= {req_sync_reg[0], link.cal_req};
         down_sync_reg <= {down_sync_reg[0], link.power_down_pin};
      end
   end

   acr_req_qual #(
      .HOLD(acr_pkg::CAL_HOLD_CYCLES)
   ) u_qual (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_level(req_s),
      .ignore(down_s || state_reg == ST_POWER_DOWN),
      .fire(fire)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_STRAP: begin
            if (strap_cnt_reg == 2'b11) state_next = ST_PWRUP_WAIT;
         end
         ST_PWRUP_WAIT: begin
            if (fire) begin
               state_next = ST_CAL;
            end else if (cnt_reg >= POWERUP_CYCLES - 1) begin
               // skipped by strap, or withheld while power-down is high
               if (skip_reg) state_next = ST_IDLE;
               else if (!down_s) state_next = ST_CAL;
            end
         end
         ST_IDLE: begin
            if (down_s) state_next = ST_POWER_DOWN;
            else if (fire) state_next = ST_CAL;
         end
         ST_CAL: begin
            // power-down waits for the end; a request that completes now is dropped
            if (cnt_reg >= CAL_CYCLES - 1) state_next = ST_IDLE;
         end
         ST_POWER_DOWN: begin
            if (!down_s) state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // sequencer and shared cycle counter
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= ST_STRAP;
         strap_cnt_reg <= 2'b00;
         skip_reg <= 1'b0;
         cnt_reg <= 32'h0000_0000;
         cal_reg <= 1'b0;
         done_reg <= 1'b0;
         down_out_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         strap_cnt_reg <= strap_cnt_reg + 2'b01;
         if (state_reg == ST_STRAP && state_next == ST_PWRUP_WAIT) begin
            skip_reg <= req_s;
         end
         if (state_next != state_reg) cnt_reg <= 32'h0000_0000;
         else if (state_reg == ST_PWRUP_WAIT && cnt_reg < POWERUP_CYCLES - 1) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
         end else if (state_reg == ST_CAL) cnt_reg <= cnt_reg + 32'h0000_0001;
         cal_reg <= (state_next == ST_CAL);
         if (state_reg == ST_CAL && state_next != ST_CAL) done_reg <= 1'b1;
         down_out_reg <= (state_next == ST_POWER_DOWN);
      end
   end

   // out-of-range: either converter beyond the 8-bit code span
   assign clip = (conv_value_a < acr_pkg::CODE_MIN) || (conv_value_a > acr_pkg::CODE_MAX)
      || (conv_value_b < acr_pkg::CODE_MIN) || (conv_value_b > acr_pkg::CODE_MAX);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flag_p_reg <= 1'b0;
         flag_n_reg <= 1'b1;
      end else begin
         // held inactive during calibration, gated by the disable bit
         flag_p_reg <= clip && !ovr_dis_reg && !cal_reg;
         flag_n_reg <= !(clip && !ovr_dis_reg && !cal_reg);
      end
   end

   // configuration writes from the host
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ap_en_reg <= acr_pkg::APERTURE_EN_RST;
         term_reg <= acr_pkg::TERM_SEL_RST;
         ovr_dis_reg <= acr_pkg::OVR_DIS_RST;
         ap_dly_reg <= acr_pkg::APERTURE_DLY_RST;
      end else if (link.cfg_wr) begin
         case (link.cfg_addr)
            acr_pkg::APERTURE_EN_ADDR: ap_en_reg <= link.cfg_wdata[acr_pkg::APERTURE_EN_BIT];
            acr_pkg::TERM_SEL_ADDR: term_reg <= link.cfg_wdata[acr_pkg::TERM_SEL_BIT];
            acr_pkg::APERTURE_DLY_ADDR: ap_dly_reg <= link.cfg_wdata;
            acr_pkg::OVR_CTRL_ADDR: ovr_dis_reg <= link.cfg_wdata[acr_pkg::OVR_DIS_BIT];
            default: ;
         endcase
      end
   end

   // per-converter full-scale range and offset words
   genvar gi;
   generate
      for (gi = 0; gi < acr_pkg::CONV_COUNT; gi++) begin : g_range
         always_ff @(posedge mclk) begin
            if (!rst_n) range_reg[gi] <= acr_pkg::RANGE_RST;
            else if (link.cfg_wr && link.cfg_addr == acr_pkg::RANGE_BASE_ADDR + 8'(gi)) begin
               range_reg[gi] <= link.cfg_wdata;
            end
         end
      end
   endgenerate

   // effective aperture delay and register reads
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ap_out_reg <= 16'h0000;
         rd_reg <= 16'h0000;
      end else begin
         ap_out_reg <= ap_en_reg ? ap_dly_reg : 16'h0000;
         case (rd_addr)
            acr_pkg::APERTURE_EN_ADDR: rd_reg <= {15'h0000, ap_en_reg};
            acr_pkg::TERM_SEL_ADDR: rd_reg <= {1'b0, term_reg, 14'h0000};
            acr_pkg::APERTURE_DLY_ADDR: rd_reg <= ap_dly_reg;
            acr_pkg::OVR_CTRL_ADDR: rd_reg <= {1'b0, ovr_dis_reg, 14'h0000};
            acr_pkg::STATUS_ADDR: rd_reg <= {13'h0000, done_reg, down_out_reg, cal_reg};
            default: rd_reg <= 16'h0000;
         endcase
      end
   end
endmodule

//--- rtl/acr_host.sv
/*
 host end: issues calibration requests on the request pin, waits on the busy
 output, drives power-down and writes configuration, broadcasting range words.
 assumes the device shares mclk but its outputs arrive as pins.
*/
`timescale 1ns/100ps
module acr_host #(
   parameter int unsigned AUTO_CAL_CYCLES = 32'(acr_pkg::AUTO_CAL_CYCLES)
) (
   input wire logic mclk,
   input wire logic rst_n,
   acr_link_if.host link,
   input wire logic start_cal,
   input wire logic down_req,
   input wire logic wr_req,
   input wire logic [acr_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [acr_pkg::DATA_W-1:0] wr_data,
   input wire logic range_set,
   input wire logic [acr_pkg::DATA_W-1:0] range_value,
   output logic wr_ready,
   output logic cal_busy,
   output logic cal_done,
   output logic over_range
);
   if (AUTO_CAL_CYCLES < 1) begin : g_bad_auto
      $error("acr_host: AUTO_CAL_CYCLES must be positive");
   end

   typedef enum logic [2:0] {
      H_IDLE,
      H_LOW,
      H_HIGH,
      H_WAIT_RUN,
      H_WAIT_END
   } acr_host_state_type;

   acr_host_state_type hs_reg;
   logic [1:0] run_sync_reg;
   logic [1:0] or_sync_reg;
   logic [1:0] orn_sync_reg;
   logic [7:0] hold_reg;
   logic [31:0] auto_reg;
   logic auto_pend_reg;
   logic pin_reg;
   logic down_reg;
   logic ready_reg;
   logic busy_reg;
   logic done_reg;
   logic or_reg;
   logic wr_reg;
   logic [acr_pkg::ADDR_W-1:0] addr_reg;
   logic [acr_pkg::DATA_W-1:0] data_reg;
   logic [2:0] bcast_reg;
   logic run_s;

   assign run_s = run_sync_reg[1];
   assign link.cal_req = pin_reg;
   assign link.power_down_pin = down_reg;
   assign link.cfg_wr = wr_reg;
   assign link.cfg_addr = addr_reg;
   assign link.cfg_wdata = data_reg;
   assign wr_ready = ready_reg;
   assign cal_busy = busy_reg;
   assign cal_done = done_reg;
   assign over_range = or_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         run_sync_reg <= 2'b00;
         or_sync_reg <= 2'b00;
         orn_sync_reg <= 2'b11;
         or_reg <= 1'b0;
         down_reg <= 1'b0;
      end else begin
         run_sync_reg <= {run_sync_reg[0], link.cal_in_progress};
         or_sync_reg <= {or_sync_reg[0], link.over_range_flag_p};
         orn_sync_reg <= {orn_sync_reg[0], link.over_range_flag_n};
         // flag only trusted while no calibration is running
         or_reg <= or_sync_reg[1] && !orn_sync_reg[1] && !run_s && !busy_reg;
         down_reg <= down_req;
      end
   end

   // one recalibration after the settling time from power-up
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         auto_reg <= 32'h0000_0000;
         auto_pend_reg <= 1'b0;
      end else if (auto_reg < AUTO_CAL_CYCLES - 1) begin
         auto_reg <= auto_reg + 32'h0000_0001;
      end else if (auto_reg == AUTO_CAL_CYCLES - 1) begin
         auto_reg <= AUTO_CAL_CYCLES;
         auto_pend_reg <= 1'b1;
      end else if (hs_reg == H_LOW) begin
         auto_pend_reg <= 1'b0;
      end
   end

   // request pin sequence and completion tracking
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hs_reg <= H_IDLE;
         hold_reg <= 8'h00;
         pin_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (hs_reg)
            H_IDLE: begin
               pin_reg <= 1'b0;
               hold_reg <= 8'h00;
               if ((start_cal || auto_pend_reg) && !down_req) begin
                  hs_reg <= H_LOW;
                  busy_reg <= 1'b1;
               end
            end
            H_LOW: begin
               // low for the full hold, then high for the full hold
               hold_reg <= hold_reg + 8'h01;
               if (hold_reg == acr_pkg::CAL_HOLD_CYCLES[7:0] - 8'h01) begin
                  pin_reg <= 1'b1;
                  hold_reg <= 8'h00;
                  hs_reg <= H_HIGH;
               end
            end
            H_HIGH: begin
               hold_reg <= hold_reg + 8'h01;
               if (hold_reg == acr_pkg::CAL_HOLD_CYCLES[7:0] - 8'h01) hs_reg <= H_WAIT_RUN;
            end
            H_WAIT_RUN: begin
               // completion learned from the busy pin, not from a timer
               if (run_s) begin
                  pin_reg <= 1'b0;
                  hs_reg <= H_WAIT_END;
               end
            end
            H_WAIT_END: begin
               if (!run_s) begin
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
                  hs_reg <= H_IDLE;
               end
            end
            default: hs_reg <= H_IDLE;
         endcase
      end
   end

   // configuration writes; a range word goes to every converter alike
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_reg <= 1'b0;
         addr_reg <= 8'h00;
         data_reg <= 16'h0000;
         bcast_reg <= 3'b000;
         ready_reg <= 1'b1;
      end else if (bcast_reg != 3'b000) begin
         wr_reg <= 1'b1;
         addr_reg <= acr_pkg::RANGE_BASE_ADDR + 8'(acr_pkg::CONV_COUNT) - {5'h00, bcast_reg};
         bcast_reg <= bcast_reg - 3'b001;
         ready_reg <= 1'b0;
      end else if (!wr_reg && range_set) begin
         wr_reg <= 1'b0;
         data_reg <= range_value;
         bcast_reg <= 3'(acr_pkg::CONV_COUNT);
         ready_reg <= 1'b0;
      end else if (!wr_reg && wr_req) begin
         wr_reg <= 1'b1;
         addr_reg <= wr_addr;
         data_reg <= wr_data;
         ready_reg <= 1'b0;
      end else begin
         wr_reg <= 1'b0;
         ready_reg <= 1'b1;
      end
   end
endmodule

//--- sim/acr_link_checker.sv
/*
 checker for the link: request pin timing, busy output, over-range pair.
 assumes it sits beside the link joining the device and host ends.
*/
`timescale 1ns/100ps
module acr_link_checker #(
   parameter int unsigned POWERUP_CYCLES = 200,
   parameter int unsigned CAL_CYCLES = 300,
   parameter int HOLD = 80
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cal_req,
   input wire logic power_down_pin,
   input wire logic cal_in_progress,
   input wire logic over_range_flag_p,
   input wire logic over_range_flag_n
);
   logic [15:0] lo_run_reg;
   logic [15:0] hi_run_reg;
   logic [23:0] run_len_reg;
   logic [23:0] since_rst_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge mclk) begin
      if (!rst_n || cal_req) lo_run_reg <= 16'h0000;
      else if (lo_run_reg != 16'hFFFF) lo_run_reg <= lo_run_reg + 16'h0001;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n || !cal_req) hi_run_reg <= 16'h0000;
      else if (hi_run_reg != 16'hFFFF) hi_run_reg <= hi_run_reg + 16'h0001;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n || !cal_in_progress) run_len_reg <= 24'h000000;
      else run_len_reg <= run_len_reg + 24'h000001;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) since_rst_reg <= 24'h000000;
      else if (since_rst_reg != 24'hFFFFFF) since_rst_reg <= since_rst_reg + 24'h000001;
   end
   ovr_pair_a: assert property (over_range_flag_p == !over_range_flag_n)
      else $error("over-range legs not complementary");
   ovr_cal_a: assert property (cal_in_progress && $past(cal_in_progress) |-> !over_range_flag_p)
      else $error("over-range set during calibration");
   cal_len_a: assert property ($fell(cal_in_progress) |-> run_len_reg == CAL_CYCLES)
      else $error("calibration length wrong");
   cal_cap_a: assert property (cal_in_progress |-> run_len_reg < CAL_CYCLES)
      else $error("calibration ran too long");
   req_low_a: assert property ($rose(cal_req) |-> lo_run_reg >= HOLD)
      else $error("request low phase too short");
   req_high_a: assert property ($fell(cal_req) |-> hi_run_reg >= HOLD)
      else $error("request high phase too short");
   cal_start_a: assert property (hi_run_reg == HOLD && !cal_in_progress && !power_down_pin
      |-> ##[1:8] $rose(cal_in_progress))
      else $error("requested calibration did not start");
   pwr_wait_a: assert property ($rose(cal_in_progress) && !cal_req
      |-> since_rst_reg > POWERUP_CYCLES)
      else $error("power-on calibration too early");
   cover property ($rose(cal_in_progress) && !cal_req);
   cover property ($rose(cal_in_progress) && cal_req);
   cover property ($rose(over_range_flag_p));
endmodule

//--- sim/adc_calibration_and_range_control_tb_top.sv
/*
 testbench: device and host on one link, a second device driven by the bench.
 assumes shortened power-up, calibration and auto-recalibration counts.
*/
`timescale 1ns/100ps
module adc_calibration_and_range_control_tb_top;
   localparam int unsigned PWR = 200;
   localparam int unsigned CALN = 300;
   logic mclk;
   logic rst_n = 1'b0;
   logic rst_b_n = 1'b0;
   logic start_cal = 1'b0;
   logic down_req = 1'b0;
   logic wr_req = 1'b0;
   logic [7:0] wr_addr = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic range_set = 1'b0;
   logic [15:0] range_value = 16'h0000;
   logic signed [9:0] conv_a = 10'sh12C;
   logic signed [9:0] conv_b = 10'sh000;
   logic [7:0] rd_addr = 8'h00;
   logic [15:0] rd_data;
   logic [15:0] ap_dly;
   logic [3:0][15:0] range_word;
   logic term, pdn, cald, wr_ready, busy, done, ovr, pdn_b, cald_b, cip;
   logic sel_b = 1'b0;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   int n_rise_m = 0;
   int n_rise_b = 0;
   acr_link_if link (.mclk(mclk));
   acr_link_if link_b (.mclk(mclk));
   assign cip = sel_b ? link_b.cal_in_progress : link.cal_in_progress;
   acr_device #(.POWERUP_CYCLES(PWR), .CAL_CYCLES(CALN)) u_acr_device (.mclk(mclk),
      .rst_n(rst_n), .link(link.dev), .conv_value_a(conv_a), .conv_value_b(conv_b),
      .rd_addr(rd_addr), .rd_data(rd_data), .term_150_sel(term), .aperture_delay(ap_dly),
      .range_word(range_word), .powered_down(pdn), .calibrated(cald));
   acr_device #(.POWERUP_CYCLES(PWR), .CAL_CYCLES(CALN)) u_acr_device_b (.mclk(mclk),
      .rst_n(rst_b_n), .link(link_b.dev), .conv_value_a(conv_a), .conv_value_b(conv_b),
      .rd_addr(rd_addr), .rd_data(), .term_150_sel(), .aperture_delay(), .range_word(),
      .powered_down(pdn_b), .calibrated(cald_b));
   acr_host #(.AUTO_CAL_CYCLES(5000)) u_acr_host (.mclk(mclk), .rst_n(rst_n),
      .link(link.host), .start_cal(start_cal), .down_req(down_req), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_data(wr_data), .range_set(range_set),
      .range_value(range_value), .wr_ready(wr_ready), .cal_busy(busy), .cal_done(done),
      .over_range(ovr));
   acr_link_checker #(.POWERUP_CYCLES(PWR), .CAL_CYCLES(CALN)) u_acr_link_checker (
      .mclk(mclk), .rst_n(rst_n), .cal_req(link.cal_req),
      .power_down_pin(link.power_down_pin), .cal_in_progress(link.cal_in_progress),
      .over_range_flag_p(link.over_range_flag_p), .over_range_flag_n(link.over_range_flag_n));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;
   always @(posedge link.cal_in_progress) n_rise_m++;
   always @(posedge link_b.cal_in_progress) n_rise_b++;
   task chkw(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chkw({15'h0000, got}, {15'h0000, exp});
   endtask
   task clk_n(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task wait_lvl(input logic lvl, input int lim, output int at);
      int n;
      n = 0;
      while (cip !== lvl && n < lim) begin
         @(negedge mclk);
         n++;
      end
      at = cyc;
   endtask
   task breq(input int lo, input int hi);
      link_b.cal_req = 1'b0;
      clk_n(lo);
      link_b.cal_req = 1'b1;
      clk_n(hi);
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (wr_ready !== 1'b1 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      wr_addr = a;
      wr_data = d;
      wr_req = 1'b1;
      clk_n(1);
      wr_req = 1'b0;
      clk_n(4);
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      rd_addr = a;
      clk_n(2);
      chkw(rd_data, e);
   endtask
   task go(output int t0);
      start_cal = 1'b1;
      clk_n(1);
      start_cal = 1'b0;
      wait_lvl(1'b1, 300, t0);
   endtask
   task t_power_on;
      int t0, t1;
      chk1(term, 1'b0);
      chkw(ap_dly, 16'h0000);
      rd(acr_pkg::APERTURE_DLY_ADDR, 16'h0000);
      chk1(link.over_range_flag_p, 1'b0);
      clk_n(PWR - 2);
      chk1(link.cal_in_progress, 1'b0);
      wait_lvl(1'b1, 20, t0);
      wait_lvl(1'b0, 400, t1);
      chkw(16'(t1 - t0), 16'(CALN));
      chk1(cald, 1'b1);
   endtask
   task t_regs;
      rd(acr_pkg::STATUS_ADDR, 16'h0004);
      wr(acr_pkg::TERM_SEL_ADDR, 16'h4000);
      chk1(term, 1'b1);
      wr(acr_pkg::APERTURE_DLY_ADDR, 16'hA5C3);
      chkw(ap_dly, 16'h0000);
      rd(acr_pkg::APERTURE_DLY_ADDR, 16'hA5C3);
      wr(acr_pkg::APERTURE_EN_ADDR, 16'h0001);
      chkw(ap_dly, 16'hA5C3);
      wr(8'h3F, 16'hFFFF);
      rd(8'h3F, 16'h0000);
      range_value = 16'h0123;
      range_set = 1'b1;
      clk_n(1);
      range_set = 1'b0;
      clk_n(8);
      for (int i = 0; i < 4; i++) chkw(range_word[i], 16'h0123);
      chk1(wr_ready, 1'b1);
   endtask
   task t_ovr;
      logic signed [9:0] va [5];
      logic [4:0] ex;
      va = '{-10'sd1, 10'sd0, 10'sd255, 10'sd256, 10'sd300};
      ex = 5'b11001;
      wr(acr_pkg::OVR_CTRL_ADDR, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         conv_a = va[i];
         conv_b = va[4 - i];
         clk_n(5);
         chk1(link.over_range_flag_p, ex[i] | ex[4 - i]);
         chk1(link.over_range_flag_n, !(ex[i] | ex[4 - i]));
         chk1(ovr, ex[i] | ex[4 - i]);
      end
      conv_b = 10'sd0;
      conv_a = 10'sd300;
   endtask
   task t_cmd;
      int t0, t1, n;
      go(t0);
      clk_n(5);
      chk1(ovr, 1'b0);
      chk1(busy, 1'b1);
      chk1(link.over_range_flag_p, 1'b0);
      wait_lvl(1'b0, 400, t1);
      chkw(16'(t1 - t0), 16'(CALN));
      n = 0;
      while (done !== 1'b1 && n < 10) begin
         @(negedge mclk);
         n++;
      end
      chk1(done, 1'b1);
      chk1(busy, 1'b0);
   endtask
   task t_down;
      int t0;
      go(t0);
      down_req = 1'b1;
      clk_n(20);
      chk1(pdn, 1'b0);
      wait_lvl(1'b0, 400, t0);
      clk_n(5);
      chk1(pdn, 1'b1);
      down_req = 1'b0;
      clk_n(8);
      chk1(pdn, 1'b0);
   endtask
   task t_strap;
      chk1(cip, 1'b0);
      chk1(cald_b, 1'b0);
      breq(50, 10);
      breq(50, 100);
      chkw(16'(n_rise_b), 16'h0000);
      breq(100, 60);
      chkw(16'(n_rise_b), 16'h0000);
   endtask
   task t_oncmd;
      int tp, t0, t1;
      breq(110, 0);
      tp = cyc;
      wait_lvl(1'b1, 120, t0);
      chk1((t0 - tp) inside {[80:88]}, 1'b1);
      breq(85, 85);
      wait_lvl(1'b0, 400, t1);
      chkw(16'(t1 - t0), 16'(CALN));
      clk_n(100);
      chkw(16'(n_rise_b), 16'h0001);
   endtask
   task t_down_ign;
      link_b.power_down_pin = 1'b1;
      clk_n(10);
      chk1(pdn_b, 1'b1);
      breq(90, 90);
      link_b.power_down_pin = 1'b0;
      clk_n(100);
      chkw(16'(n_rise_b), 16'h0001);
   endtask
   task t_down_strap;
      int t0;
      rst_b_n = 1'b0;
      link_b.cal_req = 1'b0;
      link_b.power_down_pin = 1'b1;
      clk_n(20);
      rst_b_n = 1'b1;
      clk_n(PWR + 30);
      chk1(cip, 1'b0);
      link_b.power_down_pin = 1'b0;
      wait_lvl(1'b1, 20, t0);
      chk1(cip, 1'b1);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #160000;
      n_fail++;
      test_done();
   end
   initial begin
      link_b.cal_req = 1'b1;
      link_b.power_down_pin = 1'b0;
      link_b.cfg_wr = 1'b0;
      link_b.cfg_addr = 8'h00;
      link_b.cfg_wdata = 16'h0000;
      clk_n(20);
      rst_n = 1'b1;
      rst_b_n = 1'b1;
      t_power_on();
      t_regs();
      t_ovr();
      t_cmd();
      t_down();
      sel_b = 1'b1;
      t_strap();
      t_oncmd();
      t_down_ign();
      t_down_strap();
      sel_b = 1'b0;
      if (cyc < 7500) clk_n(7500 - cyc);
      chkw(16'(n_rise_m), 16'h0004);
      test_done();
   end
endmodule
